/* verilog/nvmcs_pkg.sv */
package nvmcs_pkg;
  // ************************************
  // register offsets
  // ************************************
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_GEOM = 8'h08;
  localparam logic [7:0] OFS_IEN_CLR = 8'h0c;
  localparam logic [7:0] OFS_IEN_SET = 8'h10;
  localparam logic [7:0] OFS_IFLAG = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_ADDR = 8'h1c;
  localparam logic [7:0] OFS_LOCK = 8'h20;
  // ************************************
  // fields and reset values
  // ************************************
  localparam logic [31:0] CFG_RESET = 32'h0000_0080;
  localparam logic [31:0] CFG_WMASK = 32'h0007_039e;
  localparam int CFG_RWS_LSB = 1;
  localparam int CFG_MANUAL_WRITE_BIT = 7;
  localparam int CFG_SLEEP_LSB = 8;
  localparam int CFG_POLICY_LSB = 16;
  localparam int CFG_CACHE_OFF_BIT = 18;
  localparam int GEOM_EMU_LSB = 20;
  localparam int GEOM_PSZ_LSB = 16;
  localparam int IRQ_READY = 0;
  localparam int IRQ_ERROR = 1;
  localparam int ST_PRM = 0;
  localparam int ST_LOAD = 1;
  localparam int ST_BAD_COMMAND_ERROR = 2;
  localparam int ST_LOCKED_REGION_ERROR = 3;
  localparam int ST_MEMORY_ERROR = 4;
  localparam int ST_SB = 8;
  localparam int ADDR_W = 22;
  localparam int REGION_LSB = 18;
  localparam logic [7:0] CMD_KEY = 8'ha5;
  // ************************************
  // enumerations
  // ************************************
  typedef enum logic [1:0] {POLICY_FAST = 2'h0, POLICY_LOW_POWER = 2'h1, POLICY_DETERMINISTIC = 2'h2,
    POLICY_RSVD = 2'h3} nvmcs_policy_t;
  typedef enum logic [1:0] {WAKE_ON_FIRST_ACCESS = 2'h0, WAKE_ON_SLEEP_EXIT = 2'h1, SLEEP_RSVD = 2'h2,
    SLEEP_PRM_OFF = 2'h3} nvmcs_sleep_t;
  typedef enum logic [6:0] {CMD_ER = 7'h02, CMD_WP = 7'h04, CMD_EAR = 7'h05, CMD_WAP = 7'h06,
    CMD_EMU_ER = 7'h1a, CMD_EMU_WP = 7'h1c, CMD_LR = 7'h40, CMD_UR = 7'h41, CMD_PRM_SET = 7'h42,
    CMD_PRM_CLR = 7'h43, CMD_BUF_CLR = 7'h44, CMD_SSB = 7'h45, CMD_INVALL = 7'h46} nvmcs_cmd_t;
endpackage : nvmcs_pkg

/* verilog/nvmcs_cfg_if.sv */
`timescale 1ns/1ps
interface nvmcs_cfg_if;
  import nvmcs_pkg::*;
  logic cache_off;
  logic [1:0] cache_read_policy;
  logic [3:0] read_wait_states;
  logic [1:0] sleep_power_reduction;
  logic rd_req;
  logic rd_hit;
  logic rd_done;
  modport ctrl (output cache_off, cache_read_policy, read_wait_states, sleep_power_reduction, rd_req, rd_hit,
    input rd_done);
  modport timer (input cache_off, cache_read_policy, read_wait_states, rd_req, rd_hit, output rd_done);
  modport power (input sleep_power_reduction, rd_req);
endinterface : nvmcs_cfg_if

/* verilog/nvmcs_read_timer.sv */
`timescale 1ns/1ps
module nvmcs_read_timer
  import nvmcs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  nvmcs_cfg_if.timer cfg
);
  import nvmcs_pkg::*;
  logic [4:0] cnt_r;
  logic busy_r;
  logic [4:0] need;
  logic hit_served;

  // ************************************
  // wait states per read
  // ************************************
  always_comb
  begin
    hit_served = cfg.rd_hit && !cfg.cache_off; // R1
    case (cfg.cache_read_policy)
      POLICY_FAST: need = hit_served ? 5'h00 : {1'b0, cfg.read_wait_states}; // R2
      POLICY_LOW_POWER: need = hit_served ? 5'h00 : 5'({1'b0, cfg.read_wait_states} + 5'h01); // R3
      POLICY_DETERMINISTIC: need = {1'b0, cfg.read_wait_states}; // R4
      default: need = {1'b0, cfg.read_wait_states};
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      busy_r <= 1'b0;
      cnt_r <= 5'h00;
    end
    else if (!busy_r && cfg.rd_req && need != 5'h00)
    begin
      busy_r <= 1'b1;
      cnt_r <= need; // R10
    end
    else if (busy_r)
    begin
      cnt_r <= 5'(cnt_r - 5'h01);
      if (cnt_r == 5'h01)
        busy_r <= 1'b0;
    end
  end

  assign cfg.rd_done = (!busy_r && cfg.rd_req && need == 5'h00) || (busy_r && cnt_r == 5'h01);
endmodule : nvmcs_read_timer

/* verilog/nvmcs_power_ctl.sv */
`timescale 1ns/1ps
module nvmcs_power_ctl
  import nvmcs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  nvmcs_cfg_if.power cfg,
  input wire logic sleep_enter,
  input wire logic sleep_exit,
  input wire logic cmd_set,
  input wire logic cmd_clr,
  output logic power_reduced
);
  import nvmcs_pkg::*;
  logic auto_on;

  // ************************************
  // power reduction state
  // ************************************
  assign auto_on = cfg.sleep_power_reduction == WAKE_ON_FIRST_ACCESS ||
    cfg.sleep_power_reduction == WAKE_ON_SLEEP_EXIT; // R7

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      power_reduced <= 1'b0;
    else if (cmd_set || (sleep_enter && auto_on)) // R5 R6 R20
      power_reduced <= 1'b1;
    else if (cmd_clr || cfg.rd_req) // R5 R20
      power_reduced <= 1'b0;
    else if (sleep_exit && cfg.sleep_power_reduction == WAKE_ON_SLEEP_EXIT) // R6
      power_reduced <= 1'b0;
  end
endmodule : nvmcs_power_ctl

/* verilog/nvmcs_ctrl.sv */
`timescale 1ns/1ps
// Notes on behaviour
// R1 - cache-off bit bypasses cache for reads
// R2 - fast policy adds no miss wait states
// R3 - low-power policy adds one wait per miss
// R4 - deterministic policy: hit equals miss timing
// R5 - sleep field 0: wake on first access
// R6 - sleep field 1: wake on sleep exit
// R7 - sleep field 3: no automatic power reduction
// R8 - auto mode: last buffer word starts write
// R9 - manual mode: writes only by command
// R10 - read wait states zero to fifteen
// R11 - geometry register shows page counts
// R12 - page size code is eight shifted
// R13 - set and clear registers share enables
// R14 - error flag on any error condition
// R15 - ready flag low while busy
// R16 - status bit 4: memory failure
// R17 - status bit 3: locked region programmed
// R18 - status bit 2: bad command or key
// R19 - status bit 1: page buffer loaded
// R20 - status bit 0 shows power reduction
// R21 - address register feeds commands, auto-updated
// R22 - lock status read-only, changed by commands
// R23 - commands run only with correct key
// R24 - software issues commands only when ready
// R25 - buffer clear command ends loaded state
// R26 - interrupt while enabled flag is set
module nvmcs_ctrl
  import nvmcs_pkg::*;
#(
  parameter logic [11:0] EMU_PAGES = 12'h000,
  parameter logic [2:0] PAGE_SIZE_CODE = 3'h0,
  parameter logic [15:0] MAIN_PAGES = 16'h0000,
  parameter logic [15:0] LOCK_INIT = 16'hffff,
  parameter logic SECURITY_INIT = 1'b0
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [3:0] reg_be,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  input wire logic arr_rd_req,
  input wire logic arr_rd_hit,
  output logic arr_rd_done,
  output logic cache_bypass,
  input wire logic sleep_enter,
  input wire logic sleep_exit,
  input wire logic pb_wr,
  input wire logic pb_last_word,
  input wire logic [nvmcs_pkg::ADDR_W-1:0] pb_wr_addr,
  output logic flash_cmd_go,
  output logic [6:0] flash_cmd_code,
  output logic [nvmcs_pkg::ADDR_W-1:0] flash_addr,
  input wire logic flash_busy,
  input wire logic flash_fail,
  input wire logic flash_lock_violation,
  output logic power_reduced,
  output logic irq
);
  import nvmcs_pkg::*;

  nvmcs_cfg_if cfg_bus ();

  logic [31:0] cfg_r;
  logic [1:0] ien_r;
  logic err_flag_r;
  logic load_r;
  logic bad_command_error_r;
  logic locked_region_error_r;
  logic memory_error_r;
  logic [ADDR_W-1:0] addr_r;
  logic [15:0] lock_r;
  logic security_r;
  logic [6:0] cmd_code_r;
  logic cmd_go_r;
  logic ready;
  logic wr_en;
  logic [31:0] wmask;
  logic [31:0] w1;
  logic cmd_write;
  logic cmd_ok;
  logic cmd_bad;
  logic auto_write;
  logic page_write_cmd;
  logic buf_clr_cmd;
  logic [3:0] region;
  logic [15:0] status_word;
  logic [31:0] rd_nxt;

  // ************************************
  // decoding helpers
  // ************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = a == ofs;
  endfunction : hit

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  function automatic logic code_known(input logic [6:0] c);
    case (c)
      CMD_ER, CMD_WP, CMD_EAR, CMD_WAP, CMD_EMU_ER, CMD_EMU_WP, CMD_LR, CMD_UR,
      CMD_PRM_SET, CMD_PRM_CLR, CMD_BUF_CLR, CMD_SSB, CMD_INVALL: code_known = 1'b1;
      default: code_known = 1'b0;
    endcase
  endfunction : code_known

  function automatic logic is_page_write(input logic [6:0] c);
    is_page_write = c == CMD_WP || c == CMD_WAP || c == CMD_EMU_WP;
  endfunction : is_page_write

  assign wr_en = reg_sel && reg_wr;
  assign wmask = be_mask(reg_be);
  assign w1 = reg_wdata & wmask;

  // ************************************
  // configuration
  // ************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      cfg_r <= CFG_RESET;
    else if (wr_en && hit(reg_addr, OFS_CFG))
      cfg_r <= (cfg_r & ~(wmask & CFG_WMASK)) | (reg_wdata & wmask & CFG_WMASK);
  end

  assign cfg_bus.cache_off = cfg_r[CFG_CACHE_OFF_BIT]; // R1
  assign cfg_bus.cache_read_policy = cfg_r[CFG_POLICY_LSB +: 2];
  assign cfg_bus.read_wait_states = cfg_r[CFG_RWS_LSB +: 4];
  assign cfg_bus.sleep_power_reduction = cfg_r[CFG_SLEEP_LSB +: 2];
  assign cfg_bus.rd_req = arr_rd_req;
  assign cfg_bus.rd_hit = arr_rd_hit;
  assign arr_rd_done = cfg_bus.rd_done;
  assign cache_bypass = cfg_r[CFG_CACHE_OFF_BIT]; // R1

  nvmcs_read_timer u_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .cfg(cfg_bus.timer)
  );

  nvmcs_power_ctl u_power (
    .sys_clk(sys_clk),
    .rst(rst),
    .cfg(cfg_bus.power),
    .sleep_enter(sleep_enter),
    .sleep_exit(sleep_exit),
    .cmd_set(cmd_ok && reg_wdata[6:0] == CMD_PRM_SET),
    .cmd_clr(cmd_ok && reg_wdata[6:0] == CMD_PRM_CLR),
    .power_reduced(power_reduced)
  );

  // ************************************
  // command issue
  // ************************************
  assign ready = !flash_busy && !cmd_go_r; // R15
  assign cmd_write = wr_en && hit(reg_addr, OFS_CMD) && reg_be[1:0] == 2'b11;
  assign cmd_ok = cmd_write && reg_wdata[15:8] == CMD_KEY && code_known(reg_wdata[6:0]) && ready; // R23
  assign cmd_bad = cmd_write && !cmd_ok; // R18 R23
  assign auto_write = pb_wr && pb_last_word && !cfg_r[CFG_MANUAL_WRITE_BIT]; // R8 R9
  assign page_write_cmd = (cmd_ok && is_page_write(reg_wdata[6:0])) || auto_write;
  assign buf_clr_cmd = cmd_ok && reg_wdata[6:0] == CMD_BUF_CLR; // R25
  assign region = addr_r[REGION_LSB +: 4];

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cmd_go_r <= 1'b0;
      cmd_code_r <= 7'h00;
    end
    else
    begin
      cmd_go_r <= cmd_ok || auto_write; // R8
      if (cmd_ok)
        cmd_code_r <= reg_wdata[6:0];
      else if (auto_write)
        cmd_code_r <= CMD_WP; // R8
    end
  end

  assign flash_cmd_go = cmd_go_r;
  assign flash_cmd_code = cmd_code_r;
  assign flash_addr = addr_r; // R21

  // ************************************
  // address register
  // ************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      addr_r <= '0;
    else if (pb_wr)
      addr_r <= pb_wr_addr; // R21
    else if (wr_en && hit(reg_addr, OFS_ADDR))
      addr_r <= (addr_r & ~wmask[ADDR_W-1:0]) | (reg_wdata[ADDR_W-1:0] & wmask[ADDR_W-1:0]);
  end

  // ************************************
  // region locks and security
  // ************************************
  logic init_done_r;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      init_done_r <= 1'b0;
    else
      init_done_r <= 1'b1;
  end
  // lock image is zero in reset, takes the strap value on the first cycle after, then follows commands
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      lock_r <= 16'h0000;
    else if (!init_done_r)
      lock_r <= LOCK_INIT;
    else if (cmd_go_r && cmd_code_r == CMD_LR)
      lock_r[region] <= 1'b0; // R22
    else if (cmd_go_r && cmd_code_r == CMD_UR)
      lock_r[region] <= 1'b1; // R22
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      security_r <= 1'b0;
    else if (!init_done_r)
      security_r <= SECURITY_INIT;
    else if (cmd_go_r && cmd_code_r == CMD_SSB)
      security_r <= 1'b1;
  end

  // ************************************
  // interrupt enables
  // ************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ien_r <= 2'b00;
    else if (wr_en && hit(reg_addr, OFS_IEN_SET))
      ien_r <= ien_r | w1[1:0]; // R13
    else if (wr_en && hit(reg_addr, OFS_IEN_CLR))
      ien_r <= ien_r & ~w1[1:0]; // R13
  end

  // ************************************
  // status and error flags
  // ************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      err_flag_r <= 1'b0;
      memory_error_r <= 1'b0;
      locked_region_error_r <= 1'b0;
      bad_command_error_r <= 1'b0;
    end
    else
    begin
      if (flash_fail || flash_lock_violation || cmd_bad) // R14
        err_flag_r <= 1'b1;
      else if (wr_en && hit(reg_addr, OFS_IFLAG) && w1[IRQ_ERROR])
        err_flag_r <= 1'b0; // R14
      if (flash_fail) // R16
        memory_error_r <= 1'b1;
      else if (wr_en && hit(reg_addr, OFS_STATUS) && w1[ST_MEMORY_ERROR])
        memory_error_r <= 1'b0; // R16
      if (flash_lock_violation) // R17
        locked_region_error_r <= 1'b1;
      else if (wr_en && hit(reg_addr, OFS_STATUS) && w1[ST_LOCKED_REGION_ERROR])
        locked_region_error_r <= 1'b0; // R17
      if (cmd_bad) // R18
        bad_command_error_r <= 1'b1;
      else if (wr_en && hit(reg_addr, OFS_STATUS) && w1[ST_BAD_COMMAND_ERROR])
        bad_command_error_r <= 1'b0; // R18
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      load_r <= 1'b0;
    else if (pb_wr && !auto_write)
      load_r <= 1'b1; // R19
    else if (page_write_cmd || buf_clr_cmd) // R19 R25
      load_r <= 1'b0;
    else if (wr_en && hit(reg_addr, OFS_STATUS) && w1[ST_LOAD])
      load_r <= 1'b0; // R19
  end

  always_comb
  begin
    status_word = 16'h0000;
    status_word[ST_PRM] = power_reduced; // R20
    status_word[ST_LOAD] = load_r;
    status_word[ST_BAD_COMMAND_ERROR] = bad_command_error_r;
    status_word[ST_LOCKED_REGION_ERROR] = locked_region_error_r;
    status_word[ST_MEMORY_ERROR] = memory_error_r;
    status_word[ST_SB] = security_r;
  end

  // ************************************
  // interrupt output
  // ************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= (ien_r[IRQ_READY] && ready) || (ien_r[IRQ_ERROR] && err_flag_r); // R26
  end

  // ************************************
  // register read
  // ************************************
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    case (reg_addr)
      OFS_CFG: rd_nxt = cfg_r;
      OFS_GEOM: rd_nxt = {EMU_PAGES, 1'b0, PAGE_SIZE_CODE, MAIN_PAGES}; // R11 R12
      OFS_IEN_CLR: rd_nxt = {30'h0, ien_r}; // R13
      OFS_IEN_SET: rd_nxt = {30'h0, ien_r}; // R13
      OFS_IFLAG: rd_nxt = {30'h0, err_flag_r, ready}; // R15
      OFS_STATUS: rd_nxt = {16'h0000, status_word};
      OFS_ADDR: rd_nxt = {10'h000, addr_r};
      OFS_LOCK: rd_nxt = {16'h0000, lock_r}; // R22
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= 32'h0000_0000;
      reg_ack <= 1'b0;
    end
    else
    begin
      reg_ack <= reg_sel;
      reg_rdata <= (reg_sel && !reg_wr) ? rd_nxt : 32'h0000_0000;
    end
  end
endmodule : nvmcs_ctrl

/* bench/nvmcs_ctrl_assertions.sv */
`timescale 1ns/1ps
// ****
// port checker
// ****
module nvmcs_ctrl_assertions
  import nvmcs_pkg::*;
#(
  parameter logic [11:0] EMU_PAGES = 12'h000,
  parameter logic [2:0] PAGE_SIZE_CODE = 3'h0,
  parameter logic [15:0] MAIN_PAGES = 16'h0000
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [3:0] reg_be,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic arr_rd_req,
  input wire logic arr_rd_hit,
  input wire logic arr_rd_done,
  input wire logic cache_bypass,
  input wire logic sleep_enter,
  input wire logic sleep_exit,
  input wire logic pb_wr,
  input wire logic pb_last_word,
  input wire logic [nvmcs_pkg::ADDR_W-1:0] pb_wr_addr,
  input wire logic flash_cmd_go,
  input wire logic [6:0] flash_cmd_code,
  input wire logic [nvmcs_pkg::ADDR_W-1:0] flash_addr,
  input wire logic flash_busy,
  input wire logic power_reduced
);
  import nvmcs_pkg::*;
  logic [31:0] cfg_r;
  logic [31:0] m_w;
  logic [4:0] cnt_r;
  logic [4:0] exp_w;
  logic miss_w;
  logic cfg_w;
  logic cmd_w;
  assign cfg_w = reg_sel && reg_wr && reg_addr == OFS_CFG;
  assign cmd_w = reg_sel && reg_wr && reg_addr == OFS_CMD;
  assign m_w = {{8{reg_be[3]}}, {8{reg_be[2]}}, {8{reg_be[1]}}, {8{reg_be[0]}}} & CFG_WMASK;
  assign miss_w = !(arr_rd_hit && !cfg_r[CFG_CACHE_OFF_BIT]);
  assign exp_w = (!miss_w && cfg_r[17:16] != 2'h2) ? 5'h0 :
    {1'b0, cfg_r[4:1]} + {4'h0, miss_w && cfg_r[17:16] == 2'h1};
  // shadow of the configuration register
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      cfg_r <= CFG_RESET;
    else if (cfg_w)
      cfg_r <= (cfg_r & ~m_w) | (reg_wdata & m_w);
  // cycles spent on the current array read
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      cnt_r <= 5'h0;
    else if (arr_rd_done || !arr_rd_req)
      cnt_r <= 5'h0;
    else
      cnt_r <= cnt_r + 5'h1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_bypass; cfg_w && reg_be[2] |=> ##1 cache_bypass == $past(reg_wdata[18], 2); endproperty
  a_bypass: assert property (p_bypass) else $error("cache bypass wrong");
  property p_rd_time; arr_rd_done |-> cnt_r == exp_w; endproperty
  a_rd_time: assert property (p_rd_time) else $error("read done early");
  property p_rd_late; arr_rd_req && !arr_rd_done |-> cnt_r < exp_w; endproperty
  a_rd_late: assert property (p_rd_late) else $error("read done late");
  property p_geom; reg_sel && !reg_wr && reg_addr == OFS_GEOM
    |=> reg_rdata == {EMU_PAGES, 1'b0, PAGE_SIZE_CODE, MAIN_PAGES}; endproperty
  a_geom: assert property (p_geom) else $error("geometry wrong");
  property p_cmd; cmd_w && reg_be[1:0] == 2'b11 && reg_wdata[15:8] == CMD_KEY && reg_wdata[6:0] == 7'h44
    && !flash_busy && !flash_cmd_go |=> flash_cmd_go && flash_cmd_code == 7'h44; endproperty
  a_cmd: assert property (p_cmd) else $error("keyed command not run");
  property p_nokey; cmd_w && reg_wdata[15:8] != CMD_KEY && !pb_wr |=> !flash_cmd_go; endproperty
  a_nokey: assert property (p_nokey) else $error("command ran without key");
  property p_auto; pb_wr && pb_last_word && !cfg_r[7]
    |=> flash_cmd_go && flash_cmd_code == 7'h04 && flash_addr == $past(pb_wr_addr); endproperty
  a_auto: assert property (p_auto) else $error("auto write missing");
  property p_manual; pb_wr && cfg_r[7] && !cmd_w |=> !flash_cmd_go; endproperty
  a_manual: assert property (p_manual) else $error("write without command");
  property p_sleep_in; sleep_enter && !cfg_r[9] && !arr_rd_req |=> power_reduced; endproperty
  a_sleep_in: assert property (p_sleep_in) else $error("no power reduction");
  property p_sleep_off; sleep_enter && cfg_r[9:8] == 2'h3 && !power_reduced |=> !power_reduced; endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("reduction while off");
  property p_wake; sleep_exit && cfg_r[9:8] == 2'h1 |=> !power_reduced; endproperty
  a_wake: assert property (p_wake) else $error("no wake on exit");
  property p_access; arr_rd_req && !sleep_enter |=> !power_reduced; endproperty
  a_access: assert property (p_access) else $error("no wake on access");
endmodule : nvmcs_ctrl_assertions

bind nvmcs_ctrl nvmcs_ctrl_assertions #(.EMU_PAGES(EMU_PAGES), .PAGE_SIZE_CODE(PAGE_SIZE_CODE),
  .MAIN_PAGES(MAIN_PAGES)) u_chk (.sys_clk(sys_clk), .rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .arr_rd_req(arr_rd_req), .arr_rd_hit(arr_rd_hit), .arr_rd_done(arr_rd_done), .cache_bypass(cache_bypass),
  .sleep_enter(sleep_enter), .sleep_exit(sleep_exit), .pb_wr(pb_wr), .pb_last_word(pb_last_word),
  .pb_wr_addr(pb_wr_addr), .flash_cmd_go(flash_cmd_go), .flash_cmd_code(flash_cmd_code),
  .flash_addr(flash_addr), .flash_busy(flash_busy), .power_reduced(power_reduced));

/* bench/nvmcs_flash_model.sv */
`timescale 1ns/1ps
// ****
// flash array model
// ****
module nvmcs_flash_model #(
  parameter int BUSY_CYC = 8
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmd_go,
  input wire logic [6:0] cmd_code,
  input wire logic fail_en,
  input wire logic lockv_en,
  output logic busy,
  output logic fail,
  output logic lock_violation
);
  logic [7:0] cnt_r;
  // program and erase keep the array busy
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      cnt_r <= 8'h00;
    else if (cmd_go && cmd_code inside {7'h02, 7'h04, 7'h05, 7'h06, 7'h1a, 7'h1c})
      cnt_r <= 8'(BUSY_CYC);
    else if (cnt_r != 8'h00)
      cnt_r <= cnt_r - 8'h01;
  assign busy = cnt_r != 8'h00;
  // failures reported on the last busy cycle
  assign fail = cnt_r == 8'h01 && fail_en;
  assign lock_violation = cnt_r == 8'h01 && lockv_en;
endmodule : nvmcs_flash_model

/* bench/tb_top.sv */
`timescale 1ns/1ps
// ****
// testbench
// ****
module tb_top;
  import nvmcs_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_sel = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [3:0] reg_be = 4'hf;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic reg_ack;
  logic arr_rd_req = 1'b0;
  logic arr_rd_hit = 1'b0;
  logic arr_rd_done;
  logic cache_bypass;
  logic sleep_enter = 1'b0;
  logic sleep_exit = 1'b0;
  logic pb_wr = 1'b0;
  logic pb_last_word = 1'b0;
  logic [21:0] pb_wr_addr = 22'h0;
  logic flash_cmd_go;
  logic [6:0] flash_cmd_code;
  logic [21:0] flash_addr;
  logic flash_busy;
  logic flash_fail;
  logic flash_lock_violation;
  logic power_reduced;
  logic irq;
  logic fail_en = 1'b0;
  logic lockv_en = 1'b0;
  logic [31:0] rd_q;
  logic [15:0] tv [9] = '{16'h0031, 16'h0030, 16'h0131, 16'h0130, 16'h0231, 16'h0230, 16'h1031, 16'h00f0,
    16'h0100};
  logic [1:0] sf [3] = '{2'h0, 2'h1, 2'h3};
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  always #10 sys_clk = ~sys_clk;
  nvmcs_ctrl #(.EMU_PAGES(12'h123), .PAGE_SIZE_CODE(3'h5), .MAIN_PAGES(16'h0400)) DUT (.sys_clk(sys_clk),
    .rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .arr_rd_req(arr_rd_req), .arr_rd_hit(arr_rd_hit),
    .arr_rd_done(arr_rd_done), .cache_bypass(cache_bypass), .sleep_enter(sleep_enter), .sleep_exit(sleep_exit),
    .pb_wr(pb_wr), .pb_last_word(pb_last_word), .pb_wr_addr(pb_wr_addr), .flash_cmd_go(flash_cmd_go),
    .flash_cmd_code(flash_cmd_code), .flash_addr(flash_addr), .flash_busy(flash_busy), .flash_fail(flash_fail),
    .flash_lock_violation(flash_lock_violation), .power_reduced(power_reduced), .irq(irq));
  nvmcs_flash_model #(.BUSY_CYC(8)) u_flash (.sys_clk(sys_clk), .rst(rst), .cmd_go(flash_cmd_go),
    .cmd_code(flash_cmd_code), .fail_en(fail_en), .lockv_en(lockv_en), .busy(flash_busy), .fail(flash_fail),
    .lock_violation(flash_lock_violation));
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one register access, data taken when acknowledged
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge sys_clk);
    reg_sel = 1'b1;
    reg_wr = w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    rd_q = reg_rdata;
    reg_sel = 1'b0;
  endtask : acc
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(rd_q & m, e);
    chk({31'h0, reg_ack}, 32'h1);
  endtask : rdc
  task automatic pb(input logic last, input logic [21:0] a);
    @(negedge sys_clk);
    pb_wr = 1'b1;
    pb_last_word = last;
    pb_wr_addr = a;
    @(negedge sys_clk);
    pb_wr = 1'b0;
  endtask : pb
  task automatic slp(input logic ent);
    @(negedge sys_clk);
    sleep_enter = ent;
    sleep_exit = !ent;
    @(negedge sys_clk);
    sleep_enter = 1'b0;
    sleep_exit = 1'b0;
  endtask : slp
  // array read, counts cycles until done
  task automatic arr(input logic h, input logic [4:0] e);
    int n;
    n = 0;
    @(negedge sys_clk);
    arr_rd_hit = h;
    arr_rd_req = 1'b1;
    #1;
    while (arr_rd_done !== 1'b1 && n < 40)
    begin
      @(negedge sys_clk);
      #1;
      n++;
    end
    @(negedge sys_clk);
    arr_rd_req = 1'b0;
    chk(32'(n), {27'h0, e});
  endtask : arr
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    rdc(OFS_CFG, 32'hffffffff, 32'h80);
    acc(1'b1, OFS_GEOM, 32'h0);
    rdc(OFS_GEOM, 32'hffffffff, 32'h1235_0400);
    rdc(OFS_IFLAG, 32'hff, 32'h01);
    rdc(OFS_STATUS, 32'hffff, 32'h0);
    rdc(OFS_LOCK, 32'hffff, 32'hffff);
    acc(1'b1, OFS_IEN_SET, 32'h3);
    rdc(OFS_IEN_CLR, 32'hff, 32'h3);
    acc(1'b1, OFS_IEN_CLR, 32'h1);
    rdc(OFS_IEN_SET, 32'hff, 32'h2);
    foreach (tv[i])
    begin
      if (i < 2)
      begin
        acc(1'b1, OFS_CMD, i == 0 ? 32'h5a44 : 32'ha57f);
        rdc(OFS_STATUS, 32'h4, 32'h4);
        rdc(OFS_IFLAG, 32'h2, 32'h2);
        chk({31'h0, irq}, 32'h1);
        acc(1'b1, OFS_STATUS, 32'h4);
        acc(1'b1, OFS_IFLAG, 32'h2);
        rdc(OFS_IFLAG, 32'h2, 32'h0);
        chk({31'h0, irq}, 32'h0);
      end
    end
    pb(1'b0, 22'h012345);
    rdc(OFS_STATUS, 32'h2, 32'h2);
    rdc(OFS_ADDR, 32'hffffffff, 32'h12345);
    acc(1'b1, OFS_STATUS, 32'h2);
    rdc(OFS_STATUS, 32'h2, 32'h0);
    pb(1'b1, 22'h000010);
    rdc(OFS_IFLAG, 32'h1, 32'h1);
    acc(1'b1, OFS_CMD, 32'ha544);
    rdc(OFS_STATUS, 32'h2, 32'h0);
    acc(1'b1, OFS_ADDR, 32'h0004_0000);
    acc(1'b1, OFS_CMD, 32'ha540);
    rdc(OFS_LOCK, 32'hffff, 32'hfffd);
    acc(1'b1, OFS_CMD, 32'ha541);
    rdc(OFS_LOCK, 32'hffff, 32'hffff);
    acc(1'b1, OFS_CMD, 32'ha542);
    rdc(OFS_STATUS, 32'h1, 32'h1);
    acc(1'b1, OFS_CMD, 32'ha543);
    rdc(OFS_STATUS, 32'h1, 32'h0);
    fail_en = 1'b1;
    lockv_en = 1'b1;
    acc(1'b1, OFS_CFG, 32'h0);
    pb(1'b1, 22'h000200);
    rdc(OFS_IFLAG, 32'h1, 32'h0);
    repeat (12) @(negedge sys_clk);
    rdc(OFS_IFLAG, 32'h3, 32'h3);
    rdc(OFS_STATUS, 32'h1e, 32'h18);
    chk({31'h0, irq}, 32'h1);
    fail_en = 1'b0;
    lockv_en = 1'b0;
    foreach (tv[i])
    begin
      acc(1'b1, OFS_CFG, {13'h0, tv[i][12], tv[i][9:8], 8'h0, 1'b1, 2'b0, tv[i][7:4], 1'b0});
      arr(tv[i][0], (tv[i][0] && !tv[i][12] && tv[i][9:8] != 2'h2) ? 5'h0 :
        {1'b0, tv[i][7:4]} + {4'h0, tv[i][9:8] == 2'h1});
      chk({31'h0, cache_bypass}, {31'h0, tv[i][12]});
    end
    foreach (sf[i])
    begin
      acc(1'b1, OFS_CFG, {22'h0, sf[i], 8'h80});
      slp(1'b1);
      rdc(OFS_STATUS, 32'h1, {31'h0, sf[i] != 2'h3});
      slp(1'b0);
      rdc(OFS_STATUS, 32'h1, {31'h0, sf[i] == 2'h0});
      arr(1'b0, 5'h0);
      rdc(OFS_STATUS, 32'h1, 32'h0);
    end
    wrap_up();
  end
endmodule : tb_top
